// ===== hdl/tdm_rate_convert_delay.sv
// Purpose: Rate-converting time-slot interchange with offset and delay modes
// Assumes: Interface clock and frame pulse arrive as pins, much slower than clk_sys
// Notes: Connection memory entry is {vc, source linear channel}
`timescale 1ns/10ps
`include "tdm_params.svh"
module tdm_rate_convert_delay (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Serial link pins
  input wire logic iface_clk_in,
  input wire logic frame_pulse_in,
  input wire logic [7:0] serial_in_stream,
  output logic [7:0] serial_out_stream,
  // Configuration
  input wire logic rate_mode_select,
  input wire tdm_pkg::rate_t input_rate_field,
  input wire tdm_pkg::rate_t output_rate_field,
  input wire logic [1:0] switch_config_bits,
  input wire logic [2:0] input_offset_reg,
  // Connection memory write
  input wire logic cm_wr_en,
  input wire logic [7:0] cm_wr_chan,
  input wire logic cm_wr_vc,
  input wire logic [7:0] cm_wr_src,
  // Status
  output logic clk_fast_req,
  output logic [3:0] in_streams_used,
  output logic [3:0] out_streams_used,
  output logic [1:0] scb_active
);
  import tdm_pkg::*;

  // Buffer index minus k, modulo three
  function automatic logic [1:0] buf_sub(input logic [1:0] b, input logic [1:0] k);
    logic [2:0] s;
    s = {1'b0, b} + 3'h3 - {1'b0, k};
    if (s >= 3'h3)
      s = s - 3'h3;
    return s[1:0];
  endfunction : buf_sub

  localparam int NS = `MAX_STREAMS;
  logic iclk_s1_ff, iclk_s2_ff, iclk_s3_ff, fp_s1_ff, fp_s2_ff;
  logic [7:0] sin_s1_ff, sin_s2_ff;
  logic tick;
  rate_t in_rate, out_rate;
  logic fast;
  logic [3:0] tick_lg, in_cnt, out_cnt, dmin;
  logic [1:0] in_lg, out_lg;
  logic [2:0] in_clg, out_clg, off, out_sh;
  logic [9:0] frame_last, fc_ff, ic, in_mask, in_bit, out_mask, slot_mask;
  logic [6:0] in_chan, in_cmask, out_cmask, out_slot, nxt_slot;
  logic sample, byte_done, slot_edge, bit_edge;
  logic [1:0] in_fidx_ff, out_fidx_ff;
  logic [7:0] sh_in_ff [NS];
  logic [7:0] cap_ff [NS];
  logic [7:0] sh_out_ff [NS];
  logic [7:0] hold_ff [NS];
  logic pk_busy_ff;
  logic [2:0] pk_idx_ff;
  logic [6:0] pk_chan_ff;
  logic [1:0] pk_buf_ff;
  logic fi_ready, fo_valid, fo_ready;
  logic [17:0] fi_data, fo_data;
  fetch_st_t fs_ff;
  logic [2:0] f_idx_ff;
  logic [6:0] f_chan_ff;
  logic [1:0] f_base_ff, dm_buf;
  logic cm_rd_en, dm_rd_en, cur_ok;
  logic [7:0] cm_rd_addr, dm_rd_data;
  logic [8:0] cm_rd_data;
  logic [9:0] dm_rd_addr;
  logic [6:0] src_chan;
  logic [11:0] src_start, out_start, dmin_ticks;
  logic clk_fast_ff, nxt_fast;
  logic [3:0] in_str_ff, out_str_ff;
  logic [1:0] scb_ff;

  // Pin synchronisers; first stage feeds only the second
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      {iclk_s1_ff, iclk_s2_ff, iclk_s3_ff, fp_s1_ff, fp_s2_ff} <= 5'h00;
      sin_s1_ff <= 8'h00;
      sin_s2_ff <= 8'h00;
    end
    else
    begin
      {iclk_s1_ff, iclk_s2_ff, iclk_s3_ff} <= {iface_clk_in, iclk_s1_ff, iclk_s2_ff};
      {fp_s1_ff, fp_s2_ff} <= {frame_pulse_in, fp_s1_ff};
      sin_s1_ff <= serial_in_stream;
      sin_s2_ff <= sin_s1_ff;
    end
  end
  // One-cycle enable per interface clock rising edge
  assign tick = iclk_s2_ff && !iclk_s3_ff;

  // Rate decode; reserved code falls back to 2 Mb/s
  always_comb
  begin
    in_rate = (input_rate_field == RATE_RSV) ? RATE_2M : input_rate_field;
    out_rate = in_rate;
    if (rate_mode_select)
      out_rate = (output_rate_field == RATE_RSV) ? RATE_2M : output_rate_field;
    nxt_fast = (in_rate == RATE_8M) || (out_rate == RATE_8M);
    fast = nxt_fast;
    tick_lg = fast ? `TICK_LG_FAST : `TICK_LG_SLOW;
    frame_last = fast ? `FRAME_LAST_FAST : `FRAME_LAST_SLOW;
    in_lg = 2'(tick_lg - `BITS_LG_BASE - {2'h0, in_rate});
    out_lg = 2'(tick_lg - `BITS_LG_BASE - {2'h0, out_rate});
    in_cnt = 4'(4'h8 >> in_rate);
    out_cnt = 4'(4'h8 >> out_rate);
    in_clg = `CHAN_LG_BASE + {1'h0, in_rate};
    out_clg = `CHAN_LG_BASE + {1'h0, out_rate};
    in_cmask = 7'((8'h1 << in_clg) - 8'h1);
    out_cmask = 7'((8'h1 << out_clg) - 8'h1);
    out_sh = {1'b0, out_lg} + 3'h3;
    dmin = (out_rate == RATE_8M) ? `DMIN_8M :
      ((out_rate == RATE_4M) ? `DMIN_4M : `DMIN_2M);
  end

  // Output frame counter restarts on the frame pulse or after its last count
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fc_ff <= 10'h000;
      out_fidx_ff <= 2'h0;
    end
    else if (tick)
    begin
      if (fp_s2_ff || fc_ff == frame_last)
      begin
        fc_ff <= 10'h000;
        // A pulse on a count still at zero starts the first frame; stepping here would
        // leave the output buffer one ahead of the input side for good
        if (fc_ff != 10'h000)
          out_fidx_ff <= buf_sub(out_fidx_ff, 2'h2);
      end
      else
        fc_ff <= fc_ff + 10'h001;
    end
  end

  // Input offset: clamp to four, none at 2 Mb/s input
  always_comb
  begin
    off = 3'h0;
    if (in_rate != RATE_2M)
      off = (input_offset_reg > `MAX_OFFSET) ? `MAX_OFFSET : input_offset_reg;
    ic = (fc_ff - {7'h00, off}) & frame_last;
    in_mask = 10'((10'h001 << in_lg) - 10'h001);
    in_bit = 10'(ic >> in_lg);
    in_chan = in_bit[9:3];
    sample = tick && ((ic & in_mask) == in_mask);
    byte_done = sample && (in_bit[2:0] == 3'h7);
  end

  // Virtual input frame index follows the offset counter
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      in_fidx_ff <= 2'h0;
    else if (tick && ic == frame_last)
      in_fidx_ff <= buf_sub(in_fidx_ff, 2'h2);
  end

  // Output slot timing; fetch runs one slot ahead
  always_comb
  begin
    out_mask = 10'((10'h001 << out_lg) - 10'h001);
    slot_mask = 10'((10'h008 << out_lg) - 10'h001);
    out_slot = 7'(fc_ff >> out_sh);
    nxt_slot = (out_slot + 7'h01) & out_cmask;
    slot_edge = tick && ((fc_ff & slot_mask) == 10'h000);
    bit_edge = tick && ((fc_ff & out_mask) == 10'h000);
  end

  // Per-lane shift registers; unused output lanes load zero
  for (genvar g = 0; g < NS; g++)
  begin : g_lane
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
      if (!arst_n)
      begin
        sh_in_ff[g] <= 8'h00;
        cap_ff[g] <= 8'h00;
        sh_out_ff[g] <= 8'h00;
      end
      else
      begin
        if (sample)
          sh_in_ff[g] <= {sh_in_ff[g][6:0], sin_s2_ff[g]};
        if (byte_done)
          cap_ff[g] <= {sh_in_ff[g][6:0], sin_s2_ff[g]};
        if (slot_edge)
          sh_out_ff[g] <= (4'(g) < out_cnt) ? hold_ff[g] : 8'h00;
        else if (bit_edge)
          sh_out_ff[g] <= {sh_out_ff[g][6:0], 1'b0};
      end
    end
    assign serial_out_stream[g] = sh_out_ff[g][7];
  end

  // Pack captured bytes into the FIFO, one lane per accepted cycle
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pk_busy_ff <= 1'b0;
      pk_idx_ff <= 3'h0;
      pk_chan_ff <= 7'h00;
      pk_buf_ff <= 2'h0;
    end
    else if (byte_done)
    begin
      pk_busy_ff <= 1'b1;
      pk_idx_ff <= 3'h0;
      pk_chan_ff <= in_chan;
      pk_buf_ff <= in_fidx_ff;
    end
    else if (pk_busy_ff && fi_ready)
    begin
      if (pk_idx_ff == 3'(in_cnt - 4'h1))
        pk_busy_ff <= 1'b0;
      pk_idx_ff <= pk_idx_ff + 3'h1;
    end
  end
  assign fi_data = {pk_buf_ff, 8'(({5'h00, pk_idx_ff} << in_clg) | {1'b0, pk_chan_ff}),
    cap_ff[pk_idx_ff]};
  // Data memory port is shared: reads win, writes wait in the FIFO
  assign fo_ready = (fs_ff != F_DM);

  tdm_fifo #(.W(18), .DEPTH(`FIFO_DEPTH)) u_wr_fifo (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .in_valid(pk_busy_ff),
    .in_ready(fi_ready),
    .in_data(fi_data),
    .out_valid(fo_valid),
    .out_ready(fo_ready),
    .out_data(fo_data)
  );

  // Three frame buffers of 256 bytes
  tdm_mem #(.W(8), .DEPTH(`DM_DEPTH)) u_data_mem (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .wr_en(fo_valid && fo_ready),
    .wr_addr(fo_data[17:8]),
    .wr_data(fo_data[7:0]),
    .rd_en(dm_rd_en),
    .rd_addr(dm_rd_addr),
    .rd_data(dm_rd_data)
  );

  // Connection memory indexed by output linear channel
  tdm_mem #(.W(9), .DEPTH(`CM_DEPTH)) u_conn_mem (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .wr_en(cm_wr_en),
    .wr_addr(cm_wr_chan),
    .wr_data({cm_wr_vc, cm_wr_src}),
    .rd_en(cm_rd_en),
    .rd_addr(cm_rd_addr),
    .rd_data(cm_rd_data)
  );

  // Buffer choice: positions compared within the frame, streams play no part
  always_comb
  begin
    cm_rd_en = (fs_ff == F_CM);
    cm_rd_addr = 8'(({5'h00, f_idx_ff} << out_clg) | {1'b0, f_chan_ff});
    dm_rd_en = (fs_ff == F_DM);
    src_chan = cm_rd_data[6:0] & in_cmask;
    src_start = 12'({5'h00, src_chan} << ({1'b0, in_lg} + 3'h3));
    out_start = 12'({5'h00, f_chan_ff} << out_sh);
    dmin_ticks = 12'({8'h00, dmin} << out_sh);
    cur_ok = out_start >= src_start + dmin_ticks;
    if (cm_rd_data[8])
      dm_buf = buf_sub(f_base_ff, `CONST_LAG);
    else
      dm_buf = cur_ok ? f_base_ff : buf_sub(f_base_ff, 2'h1);
    dm_rd_addr = {dm_buf, cm_rd_data[7:0]};
  end

  // Fetch sequencer: one lane per pass of connection then data read
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fs_ff <= F_IDLE;
      f_idx_ff <= 3'h0;
      f_chan_ff <= 7'h00;
      f_base_ff <= 2'h0;
      for (int i = 0; i < NS; i++)
        hold_ff[i] <= 8'h00;
    end
    else
    begin
      unique case (fs_ff)
        F_IDLE:
          if (slot_edge)
          begin
            fs_ff <= F_CM;
            f_idx_ff <= 3'h0;
            f_chan_ff <= nxt_slot;
            f_base_ff <= (out_slot == out_cmask) ? buf_sub(out_fidx_ff, 2'h2) : out_fidx_ff;
          end
        F_CM:
          fs_ff <= F_DM;
        F_DM:
          fs_ff <= F_CAP;
        F_CAP:
        begin
          hold_ff[f_idx_ff] <= dm_rd_data;
          f_idx_ff <= f_idx_ff + 3'h1;
          fs_ff <= (f_idx_ff == 3'(out_cnt - 4'h1)) ? F_IDLE : F_CM;
        end
      endcase
    end
  end

  // Registered status
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      clk_fast_ff <= 1'b0;
      in_str_ff <= 4'h8;
      out_str_ff <= 4'h8;
      scb_ff <= 2'h0;
    end
    else
    begin
      clk_fast_ff <= nxt_fast;
      in_str_ff <= in_cnt;
      out_str_ff <= out_cnt;
      scb_ff <= rate_mode_select ? 2'h0 : switch_config_bits;
    end
  end
  assign clk_fast_req = clk_fast_ff;
  assign in_streams_used = in_str_ff;
  assign out_streams_used = out_str_ff;
  assign scb_active = scb_ff;

  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  up_conv_a: assert property (
    rate_mode_select && input_rate_field == RATE_2M && output_rate_field == RATE_4M
    |=> in_streams_used == 4'h8 && out_streams_used == 4'h4 && !clk_fast_req)
    else $error("2 to 4 stream setup wrong");
  down_conv_a: assert property (
    rate_mode_select && input_rate_field == RATE_8M && output_rate_field == RATE_2M
    |=> in_streams_used == 4'h2 && out_streams_used == 4'h8 && clk_fast_req)
    else $error("8 to 2 stream setup wrong");
  scb_ignore_a: assert property (rate_mode_select |=> scb_active == 2'h0)
    else $error("switch bits not ignored");
  offset_off_a: assert property (in_rate == RATE_2M |-> ic == fc_ff)
    else $error("offset applied at 2 Mb/s");
  offset_lag_a: assert property (
    in_rate != RATE_2M && input_offset_reg == 3'h3 |-> ((ic + 10'h003) & frame_last) == fc_ff)
    else $error("input sampling lag wrong");
  offset_clamp_a: assert property (
    in_rate != RATE_2M && input_offset_reg > 3'h4 |-> ((ic + 10'h004) & frame_last) == fc_ff)
    else $error("offset not clamped to four");
  frame_align_a: assert property (tick && fp_s2_ff |=> fc_ff == 10'h000)
    else $error("output frame not on pulse");
  const_buf_a: assert property (
    fs_ff == F_DM && cm_rd_data[8]
    |-> {f_base_ff, dm_rd_addr[9:8]} inside {4'b0001, 4'b0110, 4'b1000})
    else $error("constant delay buffer not two frames back");
  var_buf_a: assert property (
    fs_ff == F_DM && !cm_rd_data[8]
    |-> !({f_base_ff, dm_rd_addr[9:8]} inside {4'b0001, 4'b0110, 4'b1000}))
    else $error("variable delay used constant buffer");
  win_in_a: assert property (
    fs_ff == F_DM && !cm_rd_data[8] && !rate_mode_select && in_rate == RATE_2M
    && {2'h0, cm_rd_data[4:0]} + 7'h02 == f_chan_ff |-> dm_rd_addr[9:8] != f_base_ff)
    else $error("two-slot gap not delayed a frame");
  win_out_a: assert property (
    fs_ff == F_DM && !cm_rd_data[8] && !rate_mode_select && in_rate == RATE_2M
    && {2'h0, cm_rd_data[4:0]} + 7'h03 == f_chan_ff |-> dm_rd_addr[9:8] == f_base_ff)
    else $error("three-slot gap not same frame");
  const_fetch_c: cover property (fs_ff == F_DM && cm_rd_data[8]);
  var_prev_c: cover property (fs_ff == F_DM && !cm_rd_data[8] && !cur_ok);
  fifo_stall_c: cover property (pk_busy_ff && !fi_ready);
endmodule : tdm_rate_convert_delay

// ===== hdl/tdm_params.svh
// Purpose: Shared constants of the rate-converting time-slot interchange
// Assumes: Included by bare name from every design file that needs it
// Notes: Definitions only
`ifndef TDM_PARAMS_SVH
`define TDM_PARAMS_SVH
// Lane and buffer sizes
`define MAX_STREAMS 8
`define FIFO_DEPTH 4
`define DM_DEPTH 768
`define CM_DEPTH 256
// Input offset, clock periods
`define MAX_OFFSET 3'h4
// Least variable delay, in output time-slots
`define DMIN_2M 4'h3
`define DMIN_4M 4'h5
`define DMIN_8M 4'h9
// Constant delay lag in frames
`define CONST_LAG 2'h2
// Frame geometry in interface clock periods (log2 and last count)
`define TICK_LG_SLOW 4'h9
`define TICK_LG_FAST 4'ha
`define FRAME_LAST_SLOW 10'h1ff
`define FRAME_LAST_FAST 10'h3ff
`define BITS_LG_BASE 4'h8
`define CHAN_LG_BASE 3'h5
`endif

// ===== hdl/tdm_pkg.sv
// Purpose: Types shared by the rate-converting time-slot interchange
// Assumes: Nothing beyond the language
// Notes: Constants live in tdm_params.svh
package tdm_pkg;
  // Serial rate codes of the rate fields
  typedef enum logic [1:0] {RATE_2M = 2'h0, RATE_4M = 2'h1, RATE_8M = 2'h2,
    RATE_RSV = 2'h3} rate_t;
  // Output fetch sequencer, Gray along the loop except the CAP to CM step
  typedef enum logic [1:0] {F_IDLE = 2'h0, F_CM = 2'h1, F_DM = 2'h3,
    F_CAP = 2'h2} fetch_st_t;
endpackage : tdm_pkg

// ===== hdl/tdm_fifo.sv
// Purpose: Small valid/ready FIFO in front of the data memory writes
// Assumes: DEPTH is a power of two
// Notes: Full and empty come from an occupancy count
`timescale 1ns/10ps
`include "tdm_params.svh"
module tdm_fifo #(
  parameter int W = 18,
  parameter int DEPTH = `FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wp_ff, rp_ff;
  logic [AW:0] cnt_ff;
  logic push, pop;

  // Handshakes straight from the count
  assign in_ready = (cnt_ff != (AW+1)'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign out_data = mem_ff[rp_ff];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage has no reset; only the pointers matter
  always_ff @(posedge clk_sys)
  begin
    if (push)
      mem_ff[wp_ff] <= in_data;
  end

  // Pointers and occupancy
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      if (push)
        wp_ff <= wp_ff + 1'b1;
      if (pop)
        rp_ff <= rp_ff + 1'b1;
      if (push && !pop)
        cnt_ff <= cnt_ff + 1'b1;
      else if (pop && !push)
        cnt_ff <= cnt_ff - 1'b1;
    end
  end
endmodule : tdm_fifo

// ===== hdl/tdm_mem.sv
// Purpose: Simple dual-port memory with registered read data
// Assumes: One write and one read port on clk_sys
// Notes: Read data appear the cycle after rd_en
`timescale 1ns/10ps
module tdm_mem #(
  parameter int W = 8,
  parameter int DEPTH = 256,
  parameter int AW = $clog2(DEPTH)
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [W-1:0] wr_data,
  // Read port
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [W-1:0] rd_data
);
  logic [W-1:0] mem_ff [DEPTH];
  logic [W-1:0] rd_data_ff;

  // Array write
  always_ff @(posedge clk_sys)
  begin
    if (wr_en)
      mem_ff[wr_addr] <= wr_data;
  end

  // Registered read keeps the output off the array mux
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      rd_data_ff <= '0;
    else if (rd_en)
      rd_data_ff <= mem_ff[rd_addr];
  end
  assign rd_data = rd_data_ff;
endmodule : tdm_mem

// ===== sim/tdm_link_model.sv
// Purpose: Backplane side of the serial link for the rate-converting switch
// Assumes: Identical 2 Mb/s lanes, two interface clock periods per bit
// Notes: Link clock stands still until run rises and again after four frames
`timescale 1ns/10ps
module tdm_link_model #(
  parameter int HALF_NS = 105
) (
  // Start request from the bench
  input wire logic run,
  // Serial link pins
  output logic iface_clk_in,
  output logic frame_pulse_in,
  output logic [7:0] serial_in_stream,
  input wire logic [7:0] serial_out_stream
);
  logic [7:0] rx_q [4][8][32];
  logic [7:0] byte_v;
  int frame_no;

  // Byte sent on a lane slot, distinct per frame so a wrong frame shows up
  function automatic logic [7:0] pat(input int f, input int s, input int c);
    return 8'((f * 71 + s * 32 + c + 5) % 256);
  endfunction : pat

  // Frames of 512 ticks: data change on odd ticks and are sampled on the next even tick;
  // the switch moves its output after an odd tick, so capture on the even tick after it.
  // The last bit of slot 31 is never captured.
  initial
  begin
    iface_clk_in = 1'b0;
    frame_pulse_in = 1'b0;
    serial_in_stream = 8'h00;
    frame_no = 0;
    wait (run);
    // Step off the system clock edges so pin changes never race a sampling edge
    #1;
    for (int f = 0; f < 4; f++)
    begin
      for (int t = 0; t < 512; t++)
      begin
        // Pulse straddles only the rise of tick 0, so both sides agree on slot 0
        frame_pulse_in = (t == 0);
        #(HALF_NS);
        iface_clk_in = 1'b1;
        for (int s = 0; s < 8; s++)
        begin
          byte_v = pat(f, s, t / 16);
          if (t % 2 == 1)
            serial_in_stream[s] = byte_v[7 - (t / 2) % 8];
          else if (t > 0)
            rx_q[f][s][(t - 1) / 16][7 - ((t - 1) / 2) % 8] = serial_out_stream[s];
        end
        #(HALF_NS);
        iface_clk_in = 1'b0;
      end
      frame_no = f + 1;
    end
  end
endmodule : tdm_link_model

// ===== sim/tb_tdm_rate_convert_delay.sv
// Purpose: Self-checking bench for the rate-converting time-slot interchange
// Assumes: Link clock slowed to a 210 ns period so four frames fit the run
// Notes: Different-rate delay figures are not exercised on the wire
`timescale 1ns/10ps
module tb_tdm_rate_convert_delay;
  import tdm_pkg::*;
  logic clk_sys, arst_n, run, rate_mode_select, cm_wr_en, cm_wr_vc, clk_fast_req;
  rate_t input_rate_field, output_rate_field;
  logic [1:0] switch_config_bits, scb_active;
  logic [2:0] input_offset_reg;
  logic [7:0] cm_wr_chan, cm_wr_src, serial_in_stream, serial_out_stream;
  logic [3:0] in_streams_used, out_streams_used;
  logic iface_clk_in, frame_pulse_in;
  int error_cnt, compares;

  tdm_rate_convert_delay uut (.clk_sys(clk_sys), .arst_n(arst_n),
    .iface_clk_in(iface_clk_in), .frame_pulse_in(frame_pulse_in),
    .serial_in_stream(serial_in_stream), .serial_out_stream(serial_out_stream),
    .rate_mode_select(rate_mode_select), .input_rate_field(input_rate_field),
    .output_rate_field(output_rate_field), .switch_config_bits(switch_config_bits),
    .input_offset_reg(input_offset_reg), .cm_wr_en(cm_wr_en), .cm_wr_chan(cm_wr_chan),
    .cm_wr_vc(cm_wr_vc), .cm_wr_src(cm_wr_src), .clk_fast_req(clk_fast_req),
    .in_streams_used(in_streams_used), .out_streams_used(out_streams_used),
    .scb_active(scb_active));

  tdm_link_model lnk (.run(run), .iface_clk_in(iface_clk_in),
    .frame_pulse_in(frame_pulse_in), .serial_in_stream(serial_in_stream),
    .serial_out_stream(serial_out_stream));

  // 200 MHz system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // Status comparison
  task automatic cmp_st(input string what, input logic [3:0] exp, input logic [3:0] got);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_st

  // Received byte comparison
  task automatic cmp_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_byte

  // Verdict and end of run
  task automatic final_report();
    $display("Checks %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report

  // Reset held four cycles; caller sets configuration in the same step
  task automatic do_reset();
    arst_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
  endtask : do_reset

  // One connection entry, callers may chain these back to back
  task automatic cm_write(input int chan, input logic vc, input int src);
    @(posedge clk_sys);
    cm_wr_en <= 1'b1;
    cm_wr_chan <= 8'(chan);
    cm_wr_vc <= vc;
    cm_wr_src <= 8'(src);
  endtask : cm_write

  // Stream counts and clock demand for four of the six conversions, then identical mode
  task automatic test_status();
    rate_t ir [4] = '{RATE_2M, RATE_2M, RATE_4M, RATE_8M};
    rate_t orr [4] = '{RATE_4M, RATE_8M, RATE_2M, RATE_2M};
    logic [3:0] ein [4] = '{4'h8, 4'h8, 4'h4, 4'h2};
    logic [3:0] eout [4] = '{4'h4, 4'h2, 4'h8, 4'h8};
    logic [3:0] efast [4] = '{4'h0, 4'h1, 4'h0, 4'h1};
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk_sys);
      rate_mode_select <= 1'b1;
      input_rate_field <= ir[i];
      output_rate_field <= orr[i];
      switch_config_bits <= 2'h3;
      input_offset_reg <= 3'h3;
      repeat (2) @(posedge clk_sys);
      #1;
      cmp_st("in_streams", ein[i], in_streams_used);
      cmp_st("out_streams", eout[i], out_streams_used);
      cmp_st("clk_fast", efast[i], {3'h0, clk_fast_req});
      cmp_st("scb_ignored", 4'h0, {2'h0, scb_active});
    end
    // Identical mode: output field must not matter, switch bits pass through
    @(posedge clk_sys);
    rate_mode_select <= 1'b0;
    input_rate_field <= RATE_4M;
    output_rate_field <= RATE_8M;
    switch_config_bits <= 2'h2;
    input_offset_reg <= 3'h6;
    repeat (2) @(posedge clk_sys);
    #1;
    cmp_st("same_in", 4'h4, in_streams_used);
    cmp_st("same_out", 4'h4, out_streams_used);
    cmp_st("same_fast", 4'h0, {3'h0, clk_fast_req});
    cmp_st("scb_used", 4'h2, {2'h0, scb_active});
  endtask : test_status

  // Four frames of 2 Mb/s traffic; offset 4 programmed but must be ignored
  task automatic test_switch();
    @(posedge clk_sys);
    rate_mode_select <= 1'b0;
    input_rate_field <= RATE_2M;
    output_rate_field <= RATE_2M;
    switch_config_bits <= 2'h0;
    input_offset_reg <= 3'h4;
    do_reset();
    cm_write(1 * 32 + 10, 1'b0, 2 * 32 + 7);
    cm_write(3 * 32 + 9, 1'b0, 5 * 32 + 7);
    cm_write(0 * 32 + 4, 1'b0, 6 * 32 + 20);
    cm_write(2 * 32 + 3, 1'b1, 1 * 32 + 30);
    cm_write(2 * 32 + 5, 1'b0, 1 * 32 + 30);
    @(posedge clk_sys);
    cm_wr_en <= 1'b0;
    run <= 1'b1;
    wait (lnk.frame_no == 4);
    for (int f = 2; f < 4; f++)
    begin
      cmp_byte("var_same", lnk.pat(f, 2, 7), lnk.rx_q[f][1][10]);
      cmp_byte("var_next", lnk.pat(f - 1, 5, 7), lnk.rx_q[f][3][9]);
      cmp_byte("var_early", lnk.pat(f - 1, 6, 20), lnk.rx_q[f][0][4]);
      cmp_byte("const", lnk.pat(f - 2, 1, 30), lnk.rx_q[f][2][3]);
      cmp_byte("var_pick", lnk.pat(f - 1, 1, 30), lnk.rx_q[f][2][5]);
    end
  endtask : test_switch

  // Main sequence
  initial
  begin
    error_cnt = 0;
    compares = 0;
    arst_n = 1'b0;
    run = 1'b0;
    rate_mode_select = 1'b0;
    input_rate_field = RATE_2M;
    output_rate_field = RATE_2M;
    switch_config_bits = 2'h0;
    input_offset_reg = 3'h0;
    cm_wr_en = 1'b0;
    cm_wr_vc = 1'b0;
    cm_wr_chan = 8'h00;
    cm_wr_src = 8'h00;
    do_reset();
    test_status();
    test_switch();
    final_report();
  end

  // Four frames take about 430 us; allow margin before calling it a hang
  initial
  begin
    #480us;
    error_cnt++;
    $display("FAIL watchdog expected finish seen timeout");
    final_report();
  end
endmodule : tb_tdm_rate_convert_delay
